// *** hdl/acs_setup_map.vh ***
// Register map and timing constants for the converter setup control block.
// Assumes inclusion by the setup control module only.
`ifndef ACS_SETUP_MAP_VH
`define ACS_SETUP_MAP_VH

// ****************************************************************
// Register select codes
// ****************************************************************
`define ACS_RS_COMM        3'h0
`define ACS_RS_SETUP       3'h1
`define ACS_RS_DATA        3'h3

// ****************************************************************
// Setup register fields and reset value
// ****************************************************************
`define ACS_SETUP_RESET    8'h01
`define ACS_MODE_HI_BIT    7
`define ACS_MODE_LO_BIT    6
`define ACS_GAIN_MSB       5
`define ACS_GAIN_LSB       3
`define ACS_POLAR_BIT      2
`define ACS_BUF_BIT        1
`define ACS_HOLD_BIT       0

// ****************************************************************
// Communication register fields
// ****************************************************************
`define ACS_COMM_RESET     8'h00
`define ACS_COMM_ZERO_BIT  7
`define ACS_RS_MSB         6
`define ACS_RS_LSB         4
`define ACS_RW_BIT         3
`define ACS_CH_MSB         1
`define ACS_CH_LSB         0

// ****************************************************************
// Modes and timing
// ****************************************************************
`define ACS_MODE_NORMAL    2'h0
`define ACS_MODE_SELF      2'h1
`define ACS_MODE_ZERO      2'h2
`define ACS_MODE_FULL      2'h3
`define ACS_SETTLE_PERIODS 3

`endif

// *** hdl/acs_setup_ctrl.v ***
// Setup register, mode sequencer and serial port of the converter.
// Assumes the host drives the serial clock and data, and that the
// analog side answers each cycle request with conv_done pulses.
// Contract
// - Mode 00 runs continuous conversions.
// - Mode 01 runs one-step self calibration.
// - Mode bits clear after any calibration.
// - Ready high at calibration start, low after.
// - Mode 10 runs zero-scale system calibration.
// - Mode 11 runs full-scale system calibration.
// - Gain code n selects gain two to n.
// - Polarity bit zero bipolar, one unipolar.
// - Buffer bit zero bypasses, one inserts buffer.
// - Hold bit keeps filter, calibration in reset.
// - First result three output periods after release.
// - Hold leaves interface, does not raise ready.
// - Register select 001 reaches setup register.
// - Setup register resets to 01 hex.
// - Channel comes from communication register bits.
// - Calibration stores into channel's register pair.
`timescale 1ns/1ps
`include "acs_setup_map.vh"

module acs_setup_ctrl #(
	parameter DATA_W = 16
) (
	// Clock and reset
	input  wire               core_clk,
	input  wire               rst_n,
	// Serial port pins
	input  wire               ser_clk,
	input  wire               ser_din,
	input  wire               ser_cs_n,
	output reg                ser_dout_ff,
	output reg                result_ready_n_ff,
	// Analog and filter side
	input  wire               out_rate_tick,
	input  wire               conv_done,
	input  wire [DATA_W-1:0]  conv_data,
	output reg  [7:0]         pga_gain_ff,
	output reg                unipolar_ff,
	output reg                buffer_on_ff,
	output reg                filter_reset_ff,
	output reg  [1:0]         channel_ff,
	output reg  [2:0]         cal_kind_ff,
	output reg  [1:0]         cal_pair_ff,
	output reg                cal_store_ff
);

// ****************************************************************
// Local states and helpers
// ****************************************************************
localparam ST_CMD  = 3'b001;
localparam ST_WR   = 3'b010;
localparam ST_RD   = 3'b100;
localparam S_IDLE  = 3'b001;
localparam S_CAL   = 3'b010;
localparam S_SETL  = 3'b100;

// Calibration pair for a channel code; 10 shares pair 0
function [1:0] pair_of;
	input [1:0] ch;
	begin
		case (ch)
			2'h1:    pair_of = 2'h1;
			2'h3:    pair_of = 2'h2;
			default: pair_of = 2'h0;
		endcase
	end
endfunction

// Gain as a one-hot power of two
function [7:0] gain_of;
	input [2:0] code;
	begin
		gain_of = 8'h01 << code;
	end
endfunction

// ****************************************************************
// Pin synchronisers and serial clock edges
// ****************************************************************
reg [1:0] sclk_sync_ff;
reg [1:0] din_sync_ff;
reg [1:0] cs_sync_ff;
reg       sclk_prev_ff;
wire      sclk_rise = sclk_sync_ff[1] & ~sclk_prev_ff;
wire      sclk_fall = ~sclk_sync_ff[1] & sclk_prev_ff;
wire      cs_act    = ~cs_sync_ff[1];

// Reset to idle levels so no false edge or select follows reset
always @(posedge core_clk) begin
	if (!rst_n) begin
		sclk_sync_ff <= 2'h3;
		din_sync_ff  <= 2'h0;
		cs_sync_ff   <= 2'h3;
		sclk_prev_ff <= 1'b1;
	end else begin
		sclk_sync_ff <= {sclk_sync_ff[0], ser_clk};
		din_sync_ff  <= {din_sync_ff[0], ser_din};
		cs_sync_ff   <= {cs_sync_ff[0], ser_cs_n};
		sclk_prev_ff <= sclk_sync_ff[1];
	end
end

// ****************************************************************
// Registers and serial transfer engine
// ****************************************************************
reg [7:0]        setup_ff;
reg [7:0]        comm_ff;
reg [2:0]        pst_ff;
reg [4:0]        bit_cnt_ff;
reg [15:0]       shift_ff;
reg [DATA_W-1:0] data_ff;
reg [2:0]        seq_ff;
reg [1:0]        settle_ff;
wire             cal_done;
wire [1:0]       mode = setup_ff[`ACS_MODE_HI_BIT:`ACS_MODE_LO_BIT];
wire [2:0]       rsel = comm_ff[`ACS_RS_MSB:`ACS_RS_LSB];
wire [4:0]       rd_len = (rsel == `ACS_RS_DATA) ? 5'h10 : 5'h08;
wire [7:0]       nxt_cmd = {shift_ff[6:0], din_sync_ff[1]};
wire             setup_wr_done;

assign setup_wr_done = (pst_ff == ST_WR) && sclk_rise &&
	(bit_cnt_ff == 5'h07) && (rsel == `ACS_RS_SETUP);

always @(posedge core_clk) begin
	if (!rst_n) begin
		pst_ff      <= ST_CMD;
		bit_cnt_ff  <= 5'h00;
		shift_ff    <= 16'h0000;
		comm_ff     <= `ACS_COMM_RESET;
		ser_dout_ff <= 1'b1;
	end else if (!cs_act) begin
		// Deselect aborts a partial byte and any pending data phase but
		// keeps registers; a host keeps select low for a command and its
		// data bytes
		pst_ff     <= ST_CMD;
		bit_cnt_ff <= 5'h00;
	end else begin
		case (pst_ff)
			ST_CMD: begin
				if (sclk_rise) begin
					// Zero start bit frames the command byte
					if (bit_cnt_ff == 5'h00 && din_sync_ff[1]) begin
						bit_cnt_ff <= 5'h00;
					end else if (bit_cnt_ff == 5'h07) begin
						comm_ff    <= nxt_cmd;
						bit_cnt_ff <= 5'h00;
						if (nxt_cmd[`ACS_RW_BIT]) begin
							pst_ff <= ST_RD;
							case (nxt_cmd[`ACS_RS_MSB:`ACS_RS_LSB])
								`ACS_RS_COMM: shift_ff <=
									{result_ready_n_ff, nxt_cmd[6:0], 8'h00};
								`ACS_RS_SETUP: shift_ff <= {setup_ff, 8'h00};
								`ACS_RS_DATA: shift_ff <= data_ff[15:0];
								default: shift_ff <= 16'h0000;
							endcase
						end else if (nxt_cmd[`ACS_RS_MSB:`ACS_RS_LSB]
								== `ACS_RS_SETUP) begin
							pst_ff <= ST_WR;
						end
					end else begin
						shift_ff   <= {shift_ff[14:0], din_sync_ff[1]};
						bit_cnt_ff <= bit_cnt_ff + 5'h01;
					end
				end
			end
			ST_WR: begin
				if (sclk_rise) begin
					shift_ff <= {shift_ff[14:0], din_sync_ff[1]};
					if (bit_cnt_ff == 5'h07) begin
						bit_cnt_ff <= 5'h00;
						pst_ff     <= ST_CMD;
					end else begin
						bit_cnt_ff <= bit_cnt_ff + 5'h01;
					end
				end
			end
			ST_RD: begin
				// Data changes on the falling edge for the host to sample
				if (sclk_fall) begin
					ser_dout_ff <= shift_ff[15];
					shift_ff    <= {shift_ff[14:0], 1'b0};
				end
				// The byte ends on the rise at which the host takes its last
				// bit, so a new command may follow with select held low
				if (sclk_rise) begin
					if (bit_cnt_ff == rd_len - 5'h01) begin
						bit_cnt_ff <= 5'h00;
						pst_ff     <= ST_CMD;
					end else begin
						bit_cnt_ff <= bit_cnt_ff + 5'h01;
					end
				end
			end
			default: pst_ff <= ST_CMD;
		endcase
	end
end

// Setup register: host writes, hardware clears mode at calibration end
always @(posedge core_clk) begin
	if (!rst_n) begin
		setup_ff <= `ACS_SETUP_RESET;
	end else if (setup_wr_done) begin
		setup_ff <= nxt_cmd;
	end else if (cal_done) begin
		setup_ff[`ACS_MODE_HI_BIT:`ACS_MODE_LO_BIT] <= `ACS_MODE_NORMAL;
	end
end

// ****************************************************************
// Mode sequencer, settling and ready flag
// ****************************************************************
wire hold = setup_ff[`ACS_HOLD_BIT];
wire cal_req = (mode != `ACS_MODE_NORMAL);
reg  cal_go_ff;
assign cal_done = (seq_ff == S_CAL) && conv_done && !hold;

always @(posedge core_clk) begin
	if (!rst_n) begin
		seq_ff            <= S_SETL;
		settle_ff         <= 2'h0;
		cal_go_ff         <= 1'b0;
		cal_kind_ff       <= 3'h0;
		cal_pair_ff       <= 2'h0;
		cal_store_ff      <= 1'b0;
		data_ff           <= {DATA_W{1'b0}};
		result_ready_n_ff <= 1'b1;
	end else begin
		cal_store_ff <= 1'b0;
		cal_go_ff    <= setup_wr_done &&
			(nxt_cmd[`ACS_MODE_HI_BIT:`ACS_MODE_LO_BIT] != `ACS_MODE_NORMAL);
		// Ready rises on the mode write itself, even while held, so a
		// stale result is never mistaken for the calibration outcome
		if (cal_go_ff) begin
			result_ready_n_ff <= 1'b1;
		end
		if (hold) begin
			// Only filter and calibration state; ready is left alone
			seq_ff      <= S_SETL;
			settle_ff   <= 2'h0;
			cal_kind_ff <= 3'h0;
		end else begin
			case (seq_ff)
				S_IDLE: begin
					if (cal_req) begin
						seq_ff      <= S_CAL;
						cal_pair_ff <= pair_of(channel_ff);
						cal_kind_ff <= {mode == `ACS_MODE_FULL,
							mode == `ACS_MODE_ZERO,
							mode == `ACS_MODE_SELF};
					end else if (conv_done) begin
						data_ff           <= conv_data;
						result_ready_n_ff <= 1'b0;
					end
				end
				S_CAL: begin
					if (conv_done) begin
						// Result and coefficients land together
						cal_store_ff      <= 1'b1;
						data_ff           <= conv_data;
						result_ready_n_ff <= 1'b0;
						cal_kind_ff       <= 3'h0;
						seq_ff            <= S_IDLE;
					end
				end
				S_SETL: begin
					// The count restarts only when the hold bit is set again
					if (out_rate_tick) begin
						if (settle_ff == `ACS_SETTLE_PERIODS - 1) begin
							seq_ff <= S_IDLE;
						end else begin
							settle_ff <= settle_ff + 2'h1;
						end
					end
				end
				default: seq_ff <= S_IDLE;
			endcase
		end
	end
end

// ****************************************************************
// Analog front end controls
// ****************************************************************
// Controls lag the register by one cycle; the analog side only
// acts on them once the filter has been restarted
always @(posedge core_clk) begin
	if (!rst_n) begin
		pga_gain_ff     <= 8'h01;
		unipolar_ff     <= 1'b0;
		buffer_on_ff    <= 1'b0;
		filter_reset_ff <= 1'b1;
		channel_ff      <= 2'h0;
	end else begin
		pga_gain_ff     <= gain_of(setup_ff[`ACS_GAIN_MSB:`ACS_GAIN_LSB]);
		unipolar_ff     <= setup_ff[`ACS_POLAR_BIT];
		buffer_on_ff    <= setup_ff[`ACS_BUF_BIT];
		filter_reset_ff <= hold;
		channel_ff      <= comm_ff[`ACS_CH_MSB:`ACS_CH_LSB];
	end
end

endmodule // acs_setup_ctrl

// *** tb/acs_setup_properties.sv ***
// Checker for the setup control block, bound to its ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module acs_setup_properties #(
	parameter DATA_W = 16
) (
	input wire              core_clk,
	input wire              rst_n,
	input wire              ser_clk,
	input wire              ser_din,
	input wire              ser_cs_n,
	input wire              ser_dout_ff,
	input wire              result_ready_n_ff,
	input wire              out_rate_tick,
	input wire              conv_done,
	input wire [DATA_W-1:0] conv_data,
	input wire [7:0]        pga_gain_ff,
	input wire              unipolar_ff,
	input wire              buffer_on_ff,
	input wire              filter_reset_ff,
	input wire [1:0]        channel_ff,
	input wire [2:0]        cal_kind_ff,
	input wire [1:0]        cal_pair_ff,
	input wire              cal_store_ff
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_gain_onehot: assert property (
		$onehot(pga_gain_ff)) else $error("gain not one-hot");
	a_cal_single: assert property (
		$onehot0(cal_kind_ff)) else $error("two calibrations at once");
	a_pair_map: assert property (
		cal_kind_ff != 3'h0 |-> cal_pair_ff == ((channel_ff == 2'h3) ? 2'h2 :
		(channel_ff == 2'h1) ? 2'h1 : 2'h0)) else $error("bad pair");
	a_store_cal: assert property (
		cal_store_ff |-> cal_kind_ff != 3'h0 || $past(cal_kind_ff) != 3'h0)
		else $error("store outside calibration");
	a_store_pulse: assert property (
		cal_store_ff |=> !cal_store_ff) else $error("store too long");
	a_cal_clear: assert property (
		cal_store_ff |-> cal_kind_ff == 3'h0 && !result_ready_n_ff)
		else $error("calibration not ended");
	a_ready_fall: assert property (
		$fell(result_ready_n_ff) |-> $past(conv_done) || $past(conv_done, 2))
		else $error("ready without result");
	a_hold_ready: assert property (
		$rose(filter_reset_ff) && !result_ready_n_ff |=> !result_ready_n_ff)
		else $error("hold raised ready");
	a_held_quiet: assert property (
		filter_reset_ff |-> !cal_store_ff) else $error("store while held");
endmodule // acs_setup_properties

bind acs_setup_ctrl acs_setup_properties #(.DATA_W(DATA_W)) chk_u (
	.core_clk(core_clk), .rst_n(rst_n), .ser_clk(ser_clk),
	.ser_din(ser_din), .ser_cs_n(ser_cs_n), .ser_dout_ff(ser_dout_ff),
	.result_ready_n_ff(result_ready_n_ff), .out_rate_tick(out_rate_tick),
	.conv_done(conv_done), .conv_data(conv_data),
	.pga_gain_ff(pga_gain_ff), .unipolar_ff(unipolar_ff),
	.buffer_on_ff(buffer_on_ff), .filter_reset_ff(filter_reset_ff),
	.channel_ff(channel_ff), .cal_kind_ff(cal_kind_ff),
	.cal_pair_ff(cal_pair_ff), .cal_store_ff(cal_store_ff));

// *** tb/acs_host_model.sv ***
// Host side of the four-wire serial port, one byte per call.
// Runs the serial clock at 33 core clock periods per bit.
`timescale 1ns/1ps
module acs_host_model (
	input  wire core_clk,
	input  wire ser_dout,
	output reg  ser_clk,
	output reg  ser_din,
	output reg  ser_cs_n
);
	initial begin
		ser_clk = 1'b1;
		ser_din = 1'b1;
		ser_cs_n = 1'b1;
	end
	// Data changes on the fall, read bits taken just before the rise
	task xfer(input [7:0] tx, output [7:0] rx);
		integer i;
		begin
			@(posedge core_clk) ser_cs_n <= 1'b0;
			for (i = 7; i >= 0; i = i - 1) begin
				@(posedge core_clk);
				ser_clk <= 1'b0;
				ser_din <= tx[i];
				repeat (16) @(posedge core_clk);
				rx[i] = ser_dout;
				ser_clk <= 1'b1;
				repeat (16) @(posedge core_clk);
			end
			// Select stays low: the port drops a transaction on deselect
		end
	endtask
	// Ends a transaction; the released line must not look like held data
	task deselect;
		begin
			@(posedge core_clk);
			ser_din <= ~ser_din;
			ser_cs_n <= 1'b1;
			repeat (4) @(posedge core_clk);
		end
	endtask
endmodule // acs_host_model

// *** tb/acs_setup_ctrl_tb.sv ***
// Self-checking bench for the setup control block.
// Assumes the bench plays the filter side and the host model the port.
`timescale 1ns/1ps
module acs_setup_ctrl_tb;
	reg         core_clk = 1'b0;
	reg         rst_n = 1'b0;
	reg         out_rate_tick = 1'b0;
	reg         conv_done = 1'b0;
	reg  [15:0] conv_data = 16'h0000;
	reg  [7:0]  store_cnt = 8'h00;
	reg  [7:0]  r;
	reg  [15:0] data_word;
	integer     bad_count = 0;
	integer     check_count = 0;
	integer     i;
	wire        sclk, sdin, scs_n, sdout, rdy_n, unip, bufon, fres, stor;
	wire [7:0]  gain;
	wire [1:0]  chan, pair;
	wire [2:0]  kind;
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) if (stor === 1'b1) store_cnt <= store_cnt + 8'h01;
	acs_host_model host_u (.core_clk(core_clk), .ser_dout(sdout),
		.ser_clk(sclk), .ser_din(sdin), .ser_cs_n(scs_n));
	acs_setup_ctrl dut_u (.core_clk(core_clk), .rst_n(rst_n),
		.ser_clk(sclk), .ser_din(sdin), .ser_cs_n(scs_n),
		.ser_dout_ff(sdout), .result_ready_n_ff(rdy_n),
		.out_rate_tick(out_rate_tick), .conv_done(conv_done),
		.conv_data(conv_data), .pga_gain_ff(gain), .unipolar_ff(unip),
		.buffer_on_ff(bufon), .filter_reset_ff(fres), .channel_ff(chan),
		.cal_kind_ff(kind), .cal_pair_ff(pair), .cal_store_ff(stor));
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task chk(input [7:0] got, input [7:0] exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("unexpected at %0t: %h vs %h", $time, got, exp);
			end
		end
	endtask
	task wr_setup(input [1:0] ch, input [7:0] v);
		begin
			host_u.xfer({6'h04, ch}, r);
			host_u.xfer(v, r);
			host_u.deselect;
		end
	endtask
	// One command byte, then one read byte into r
	task rd_byte(input [7:0] cmd);
		begin
			host_u.xfer(cmd, r);
			host_u.xfer(8'h00, r);
			host_u.deselect;
		end
	endtask
	task rd_setup(input [1:0] ch);
		begin
			rd_byte({6'h06, ch});
		end
	endtask
	// Data register read: two bytes, high byte first
	task rd_data(input [1:0] ch);
		begin
			host_u.xfer({6'h0e, ch}, r);
			host_u.xfer(8'h00, r);
			data_word[15:8] = r;
			host_u.xfer(8'h00, r);
			data_word[7:0] = r;
			host_u.deselect;
		end
	endtask
	// w[1] is a finished result, w[0] an output-rate period
	task pulse(input [1:0] w);
		begin
			@(posedge core_clk) {conv_done, out_rate_tick} <= w;
			conv_data <= conv_data + 16'h1111;
			@(posedge core_clk) {conv_done, out_rate_tick} <= 2'h0;
			repeat (4) @(posedge core_clk);
		end
	endtask
	task results;
		begin
			$display("checks %0d errors %0d", check_count, bad_count);
			if (bad_count == 0 && check_count > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		#400000;
		bad_count = bad_count + 1;
		results;
	end
	initial begin
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk({rdy_n, fres, gain[0]}, 8'h07);
		rd_byte(8'h08);
		chk(r, 8'h88);
		rd_setup(2'h0);
		chk(r, 8'h01);
		for (i = 0; i < 8; i = i + 1) begin
			wr_setup(2'h0, {2'h0, i[2:0], i[0], i[1], 1'b1});
			chk(gain, 8'h01 << i);
			chk(unip, i[0]);
			chk(bufon, i[1]);
			rd_setup(2'h0);
			chk(r, {2'h0, i[2:0], i[0], i[1], 1'b1});
		end
		wr_setup(2'h0, 8'h00);
		chk(fres, 1'b0);
		pulse(2'h1);
		pulse(2'h1);
		pulse(2'h2);
		chk(rdy_n, 1'b1);
		pulse(2'h1);
		pulse(2'h2);
		chk(rdy_n, 1'b0);
		rd_data(2'h0);
		chk(data_word[15:8], conv_data[15:8]);
		chk(data_word[7:0], conv_data[7:0]);
		// Every calibration mode, every channel
		for (i = 0; i < 4; i = i + 1) begin
			wr_setup(i[1:0], {(i[1:0] % 2'h3) + 2'h1, 6'h00});
			repeat (4) @(posedge core_clk);
			chk(rdy_n, 1'b1);
			chk(kind, 8'h01 << (i % 3));
			chk(chan, i[1:0]);
			chk(pair, (i == 3) ? 8'h02 : (i == 1) ? 8'h01 : 8'h00);
			pulse(2'h2);
			chk(store_cnt, i + 1);
			chk(rdy_n, 1'b0);
			rd_setup(i[1:0]);
			chk(r, 8'h00);
		end
		rd_data(2'h3);
		chk(data_word[15:8], conv_data[15:8]);
		chk(data_word[7:0], conv_data[7:0]);
		rd_byte(8'h08);
		chk(r, 8'h08);
		wr_setup(2'h0, 8'h01);
		chk(fres, 1'b1);
		chk(rdy_n, 1'b0);
		pulse(2'h2);
		chk(store_cnt, 8'h04);
		results;
	end
endmodule // acs_setup_ctrl_tb
